// >>> core/bscan_regs.svh
// Purpose: constants of the boundary-scan test logic
// Assumes: 50 MHz system clock
// Notes: definitions only
`ifndef BSCAN_REGS_SVH
`define BSCAN_REGS_SVH

// ==========================================================
// Instruction register
`define IR_WIDTH 4
`define IR_EXTEST 4'h0
`define IR_IDCODE 4'h1
`define IR_SAMPLE 4'h2
`define IR_DEVRST 4'hC
`define IR_BYPASS 4'hF
`define IR_CAPTURE_VAL 4'h1

// ==========================================================
// Data registers and identification layout
`define ID_WIDTH 32
`define ID_VERSION_LSB 28
`define ID_PART_LSB 12
`define ID_MAKER_LSB 1
`define PIN_COUNT 8
`define TMS_RESET_CLOCKS 3'h5

// ==========================================================
// Timing
`define CLK_PERIOD_NS 20
`define STARTUP_SHORT_NS 64000
`define STARTUP_LONG_NS 4000000
`define STARTUP_CNT_WIDTH 18

`endif

// >>> core/bscan_pkg.sv
// Purpose: shared types of the boundary-scan test logic
// Assumes: bscan_regs.svh holds the numbers
// Notes: types only
package bscan_pkg;
`include "bscan_regs.svh"

    // ======================================================
    // Test access port controller states
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
    } tap_state_e;

    // Drive of the port pins, value and enable
    typedef struct packed {
        logic [`PIN_COUNT-1:0] out;
        logic [`PIN_COUNT-1:0] oe;
    } pin_bus_s;

    // Per-chain strobes, one system clock wide
    typedef struct packed {
        logic capture;
        logic shift;
        logic update;
    } scan_ctl_s;
endpackage

// >>> core/bscan_sync3.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: din is asynchronous to clock
// Notes: edges are one-cycle strobes
`timescale 1ns/10ps
module bscan_sync3 #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clock, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic din, // Asynchronous input
    output logic lvl, // Filtered level
    output logic rise, // Rising strobe
    output logic fall // Falling strobe
);
    logic s1_ff, s2_ff, s3_ff, lvl_ff;
    logic nxt_lvl;

    // ======================================================
    // Level only moves when stages two and three agree
    always_comb begin
        nxt_lvl = (s2_ff == s3_ff) ? s3_ff : lvl_ff;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s1_ff <= RST_VAL;
            s2_ff <= RST_VAL;
            s3_ff <= RST_VAL;
            lvl_ff <= RST_VAL;
        end else begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            lvl_ff <= nxt_lvl;
        end
    end

    assign lvl = lvl_ff;
    assign rise = nxt_lvl & ~lvl_ff;
    assign fall = ~nxt_lvl & lvl_ff;
endmodule

// >>> core/bscan_pin_cell.sv
// Purpose: two-stage scan cell with update latch for one port pin
// Assumes: strobes already gated by chain selection
// Notes: lower stage holds control, upper holds data
`timescale 1ns/10ps
module bscan_pin_cell (
    input wire logic clock, // System clock
    input wire logic srst, // Synchronous reset
    input bscan_pkg::scan_ctl_s ctl, // Capture, shift, update strobes
    input wire logic si, // Serial in from the higher cell
    input wire logic pin_lvl, // Synchronised pin level
    input wire logic oe_cur, // Enable now on the pin
    output logic so, // Serial out to the lower cell
    output logic upd_dat, // Latched output value
    output logic upd_ctl // Latched output enable
);
    import bscan_pkg::*;
    logic dat_ff, ctl_ff, upd_dat_ff, upd_ctl_ff;
    logic nxt_dat, nxt_ctl, nxt_upd_dat, nxt_upd_ctl;

    // ======================================================
    // Capture observes the pin, shift moves toward the chain's LSB
    always_comb begin
        nxt_dat = dat_ff;
        nxt_ctl = ctl_ff;
        nxt_upd_dat = upd_dat_ff;
        nxt_upd_ctl = upd_ctl_ff;
        if (ctl.capture) begin
            nxt_dat = pin_lvl; // [R05]
            nxt_ctl = oe_cur; // [R06]
        end else if (ctl.shift) begin
            nxt_dat = si; // [R02]
            nxt_ctl = dat_ff; // [R02]
        end
        if (ctl.update) begin
            nxt_upd_dat = dat_ff; // [R25]
            nxt_upd_ctl = ctl_ff; // [R25]
        end
    end

    // Latches reset off so a first external test drives nothing
    always_ff @(posedge clock) begin
        if (srst) begin
            dat_ff <= 1'b0;
            ctl_ff <= 1'b0;
            upd_dat_ff <= 1'b0;
            upd_ctl_ff <= 1'b0;
        end else begin
            dat_ff <= nxt_dat;
            ctl_ff <= nxt_ctl;
            upd_dat_ff <= nxt_upd_dat;
            upd_ctl_ff <= nxt_upd_ctl;
        end
    end

    assign so = ctl_ff;
    assign upd_dat = upd_dat_ff;
    assign upd_ctl = upd_ctl_ff;
endmodule

// >>> core/bscan_top.sv
// Purpose: boundary-scan test logic behind a four-wire test port
// Assumes: test clock sampled by the 50 MHz system clock
// Notes: core clock of the host chip is not needed here
//
// Overview of operation
// [R01] Instruction register is four bits, sixteen possible opcodes.
// [R02] Every shift path moves LSB in first and out first.
// [R03] Opcode 0x0 selects the pin boundary chain for external test.
// [R04] External test drives latched chain values onto pins at once.
// [R05] External test: capture samples pins, update drives outputs.
// [R06] Chain reaches pull-up disable, output control, output and input data. Pull-up disable has no chain bit here; it follows chain selection.
// [R07] Opcode 0x1 selects the 32-bit identification; default after reset.
// [R08] Identification capture loads the fixed word; shift moves it out.
// [R09] Top four identification bits hold the version.
// [R10] Sixteen-bit part number sits below the version.
// [R11] Eleven-bit maker code sits below the part number.
// [R12] Opcode 0x2 selects the chain for snapshot and preload.
// [R13] Instruction_a update fills latches only, pins untouched.
// [R14] Controller preloads safe values before first external test.
// [R15] Opcode 0xC selects the reset bit; controller is never reset.
// [R16] Device held in reset while the reset bit is one.
// [R17] Reset bit is unlatched; reset acts while still shifting.
// [R18] After the bit clears, reset lasts the chosen start-up time.
// [R19] No high-impedance opcode; device reset tri-states port outputs. Under external test the latches still drive them here.
// [R20] Opcode 0xF selects a one-stage bypass between TDI and TDO.
// [R21] Bypass capture loads zero.
// [R22] Port works only with fuse set and disable bit clear.
// [R23] Works with no core clock, test clock may be faster.
// [R24] Five test clocks with TMS high reach Test-Logic-Reset.
// [R25] Latched data registers update only in Update-DR.
// [R26] Unassigned opcodes select the bypass stage.
`timescale 1ns/10ps
`include "bscan_regs.svh"
module bscan_top #(
    parameter logic [3:0] ID_VERSION = 4'h0, // Revision, arbitrary
    parameter logic [15:0] ID_PART = 16'h5A5A, // Arbitrary value
    parameter logic [10:0] ID_MAKER = 11'h155, // Arbitrary value
    parameter int STARTUP_LONG_CYC =
        (`STARTUP_LONG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    input wire logic clock, // System clock
    input wire logic srst, // Synchronous reset, high
    input wire logic tck, // Test clock pin
    input wire logic tms, // Test mode select pin
    input wire logic tdi, // Test data in pin
    output logic tdo, // Test data out
    output logic tdo_oe, // Test data out enable
    input wire logic test_port_enable_fuse, // Port enable fuse
    input wire logic test_port_disable_bit, // Disable bit from core_control_register
    input wire logic ext_reset_n, // External reset pin, low
    input wire logic clk_opt_long, // Clock option picks long start-up
    input bscan_pkg::pin_bus_s core_pins, // Functional pin drive
    input wire logic [`PIN_COUNT-1:0] pin_in, // Pin input levels
    output logic [`PIN_COUNT-1:0] pin_out, // Pin output value
    output logic [`PIN_COUNT-1:0] pin_oe, // Pin output enable
    output logic pullup_dis, // Pull-up disable in scan
    output logic core_reset // Device reset, high
);
    import bscan_pkg::*;

    localparam logic [`STARTUP_CNT_WIDTH-1:0] SHORT_CYC = `STARTUP_CNT_WIDTH'(
        (`STARTUP_SHORT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);
    localparam logic [`STARTUP_CNT_WIDTH-1:0] LONG_CYC =
        `STARTUP_CNT_WIDTH'(STARTUP_LONG_CYC);
    localparam logic [`ID_WIDTH-1:0] ID_WORD = (`ID_WIDTH'(ID_VERSION) << `ID_VERSION_LSB)
        | (`ID_WIDTH'(ID_PART) << `ID_PART_LSB)
        | (`ID_WIDTH'(ID_MAKER) << `ID_MAKER_LSB) | `ID_WIDTH'(1); // [R09] [R10] [R11]

    // ======================================================
    // Pin synchronisers
    logic tck_rise, tck_fall, tms_lvl, tdi_lvl, ext_rst_n_lvl;
    logic [`PIN_COUNT-1:0] pin_lvl;

    bscan_sync3 u_tck (.clock(clock), .srst(srst), .din(tck), .lvl(),
        .rise(tck_rise), .fall(tck_fall));
    bscan_sync3 u_tms (.clock(clock), .srst(srst), .din(tms), .lvl(tms_lvl),
        .rise(), .fall());
    bscan_sync3 u_tdi (.clock(clock), .srst(srst), .din(tdi), .lvl(tdi_lvl),
        .rise(), .fall());
    bscan_sync3 #(.RST_VAL(1'b1)) u_rst (.clock(clock), .srst(srst),
        .din(ext_reset_n), .lvl(ext_rst_n_lvl), .rise(), .fall());

    // ======================================================
    // Registers of the test controller
    tap_state_e state_ff, nxt_state;
    logic [`IR_WIDTH-1:0] ir_sr_ff, nxt_ir_sr, ir_ff, nxt_ir;
    logic [`ID_WIDTH-1:0] id_sr_ff, nxt_id_sr;
    logic byp_ff, nxt_byp, rst_bit_ff, nxt_rst_bit;
    logic tdo_ff, nxt_tdo, tdo_oe_ff, nxt_tdo_oe;
    logic [2:0] tms_cnt_ff, nxt_tms_cnt;
    logic port_en, sel_chain, sel_id, sel_rst, dr_lsb;
    scan_ctl_s chain_ctl;
    logic [`PIN_COUNT:0] chain_w;
    pin_bus_s latch_bus;
    logic [`STARTUP_CNT_WIDTH-1:0] cnt_ff, nxt_cnt;
    logic core_reset_ff, nxt_core_reset, pud_ff, nxt_pud, reset_src;
    logic [`PIN_COUNT-1:0] pin_out_ff, nxt_pin_out, pin_oe_ff, nxt_pin_oe;

    // Data register selection from the current opcode
    assign port_en = test_port_enable_fuse & ~test_port_disable_bit; // [R22]
    assign sel_chain = (ir_ff == `IR_EXTEST) || (ir_ff == `IR_SAMPLE); // [R03] [R12]
    assign sel_id = (ir_ff == `IR_IDCODE); // [R07]
    assign sel_rst = (ir_ff == `IR_DEVRST); // [R15]
    // Anything else lands on the bypass stage
    assign dr_lsb = sel_chain ? chain_w[0] : sel_id ? id_sr_ff[0] :
        sel_rst ? rst_bit_ff : byp_ff; // [R20] [R26]

    // Chain strobes; test clock edges alone pace the scan
    assign chain_ctl.capture = port_en & tck_rise & sel_chain & (state_ff == CAP_DR); // [R23]
    assign chain_ctl.shift = port_en & tck_rise & sel_chain & (state_ff == SH_DR);
    assign chain_ctl.update = port_en & tck_fall & sel_chain & (state_ff == UPD_DR); // [R25]
    assign chain_w[`PIN_COUNT] = tdi_lvl;

    // ======================================================
    // Boundary chain: bit 2i is control, bit 2i+1 is data of pin i
    genvar gi;
    generate
        for (gi = 0; gi < `PIN_COUNT; gi++) begin : g_cell
            bscan_pin_cell u_cell (
                .clock(clock),
                .srst(srst),
                .ctl(chain_ctl),
                .si(chain_w[gi+1]),
                .pin_lvl(pin_lvl[gi]),
                .oe_cur(pin_oe_ff[gi]),
                .so(chain_w[gi]),
                .upd_dat(latch_bus.out[gi]),
                .upd_ctl(latch_bus.oe[gi])
            );
            bscan_sync3 u_pin (.clock(clock), .srst(srst), .din(pin_in[gi]),
                .lvl(pin_lvl[gi]), .rise(), .fall());
        end
    endgenerate

    // ======================================================
    // Controller state, instruction and small data registers
    always_comb begin
        nxt_state = state_ff;
        nxt_ir_sr = ir_sr_ff;
        nxt_ir = ir_ff;
        nxt_id_sr = id_sr_ff;
        nxt_byp = byp_ff;
        nxt_rst_bit = rst_bit_ff;
        nxt_tdo = tdo_ff;
        nxt_tdo_oe = tdo_oe_ff;
        nxt_tms_cnt = tms_cnt_ff;
        if (!port_en) begin
            nxt_state = TLR; // [R22]
            nxt_tdo_oe = 1'b0;
        end else if (tck_rise) begin
            nxt_tms_cnt = tms_lvl ? ((tms_cnt_ff == `TMS_RESET_CLOCKS) ?
                tms_cnt_ff : tms_cnt_ff + 3'h1) : 3'h0;
            case (state_ff)
                TLR: nxt_state = tms_lvl ? TLR : RTI; // [R24]
                RTI: nxt_state = tms_lvl ? SEL_DR : RTI;
                SEL_DR: nxt_state = tms_lvl ? SEL_IR : CAP_DR;
                CAP_DR: nxt_state = tms_lvl ? EX1_DR : SH_DR;
                SH_DR: nxt_state = tms_lvl ? EX1_DR : SH_DR;
                EX1_DR: nxt_state = tms_lvl ? UPD_DR : PA_DR;
                PA_DR: nxt_state = tms_lvl ? EX2_DR : PA_DR;
                EX2_DR: nxt_state = tms_lvl ? UPD_DR : SH_DR;
                UPD_DR: nxt_state = tms_lvl ? SEL_DR : RTI;
                SEL_IR: nxt_state = tms_lvl ? TLR : CAP_IR; // [R24]
                CAP_IR: nxt_state = tms_lvl ? EX1_IR : SH_IR;
                SH_IR: nxt_state = tms_lvl ? EX1_IR : SH_IR;
                EX1_IR: nxt_state = tms_lvl ? UPD_IR : PA_IR;
                PA_IR: nxt_state = tms_lvl ? EX2_IR : PA_IR;
                EX2_IR: nxt_state = tms_lvl ? UPD_IR : SH_IR;
                UPD_IR: nxt_state = tms_lvl ? SEL_DR : RTI;
                default: nxt_state = TLR;
            endcase
            case (state_ff)
                CAP_IR: nxt_ir_sr = `IR_CAPTURE_VAL;
                SH_IR: nxt_ir_sr = {tdi_lvl, ir_sr_ff[`IR_WIDTH-1:1]}; // [R01] [R02]
                CAP_DR: begin
                    if (sel_id) begin
                        nxt_id_sr = ID_WORD; // [R08]
                    end
                    nxt_byp = 1'b0; // [R21]
                end
                SH_DR: begin
                    if (sel_id) begin
                        nxt_id_sr = {tdi_lvl, id_sr_ff[`ID_WIDTH-1:1]}; // [R02] [R08]
                    end else if (sel_rst) begin
                        nxt_rst_bit = tdi_lvl; // [R17]
                    end else if (!sel_chain) begin
                        nxt_byp = tdi_lvl; // [R20]
                    end
                end
                default: ;
            endcase
        end else if (tck_fall) begin
            // Output changes on the falling test clock edge
            nxt_tdo_oe = (state_ff == SH_IR) || (state_ff == SH_DR);
            if (state_ff == SH_IR) begin
                nxt_tdo = ir_sr_ff[0]; // [R02]
            end else if (state_ff == SH_DR) begin
                nxt_tdo = dr_lsb;
            end
            if (state_ff == UPD_IR) begin
                nxt_ir = ir_sr_ff; // [R04]
            end
        end
        // Reset state forces the default opcode; the reset bit is left alone
        if (state_ff == TLR) begin
            nxt_ir = `IR_IDCODE; // [R07] [R15]
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state_ff <= TLR;
            ir_sr_ff <= `IR_CAPTURE_VAL;
            ir_ff <= `IR_IDCODE;
            id_sr_ff <= '0;
            byp_ff <= 1'b0;
            rst_bit_ff <= 1'b0;
            tdo_ff <= 1'b0;
            tdo_oe_ff <= 1'b0;
            tms_cnt_ff <= 3'h0;
        end else begin
            state_ff <= nxt_state;
            ir_sr_ff <= nxt_ir_sr;
            ir_ff <= nxt_ir;
            id_sr_ff <= nxt_id_sr;
            byp_ff <= nxt_byp;
            rst_bit_ff <= nxt_rst_bit;
            tdo_ff <= nxt_tdo;
            tdo_oe_ff <= nxt_tdo_oe;
            tms_cnt_ff <= nxt_tms_cnt;
        end
    end

    // ======================================================
    // Device reset, start-up stretch and pin drive
    // Scan drive wins over reset so external test keeps working in reset
    assign reset_src = rst_bit_ff | ~ext_rst_n_lvl; // [R16]
    always_comb begin
        nxt_cnt = cnt_ff;
        if (reset_src) begin
            nxt_cnt = clk_opt_long ? LONG_CYC : SHORT_CYC; // [R18]
        end else if (cnt_ff != '0) begin
            nxt_cnt = cnt_ff - `STARTUP_CNT_WIDTH'(1); // [R18]
        end
        nxt_core_reset = reset_src | (cnt_ff != '0); // [R16] [R17]
        nxt_pud = port_en & sel_chain; // [R06]
        if (port_en && ir_ff == `IR_EXTEST) begin
            nxt_pin_out = latch_bus.out; // [R04] [R05]
            nxt_pin_oe = latch_bus.oe; // [R04] [R05]
        end else if (core_reset_ff) begin
            nxt_pin_out = '0; // [R19]
            nxt_pin_oe = '0; // [R19]
        end else begin
            nxt_pin_out = core_pins.out; // [R13]
            nxt_pin_oe = core_pins.oe; // [R13]
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            cnt_ff <= '0;
            core_reset_ff <= 1'b1;
            pud_ff <= 1'b0;
            pin_out_ff <= '0;
            pin_oe_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
            core_reset_ff <= nxt_core_reset;
            pud_ff <= nxt_pud;
            pin_out_ff <= nxt_pin_out;
            pin_oe_ff <= nxt_pin_oe;
        end
    end

    assign tdo = tdo_ff;
    assign tdo_oe = tdo_oe_ff;
    assign pin_out = pin_out_ff;
    assign pin_oe = pin_oe_ff;
    assign pullup_dis = pud_ff;
    assign core_reset = core_reset_ff;

    // ======================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    tms_five_reset_a: assert property ( // [R24]
        port_en && tck_rise && tms_lvl && tms_cnt_ff >= 3'h4 |=> state_ff == TLR)
        else $error("five TMS-high clocks did not reach reset state");
    idcode_default_a: assert property ( // [R07]
        state_ff == TLR |=> ir_ff == `IR_IDCODE)
        else $error("reset state did not select identification");
    id_capture_a: assert property ( // [R08]
        port_en && tck_rise && state_ff == CAP_DR && sel_id |=> id_sr_ff == ID_WORD)
        else $error("identification capture wrong");
    bypass_zero_a: assert property ( // [R21]
        port_en && tck_rise && state_ff == CAP_DR |=> byp_ff == 1'b0)
        else $error("bypass capture not zero");
    reset_now_a: assert property ( // [R17]
        $rose(rst_bit_ff) |=> core_reset_ff)
        else $error("reset bit did not reset at once");
    startup_hold_a: assert property ( // [R18]
        $fell(rst_bit_ff) && ext_rst_n_lvl |=> core_reset_ff [*3])
        else $error("start-up hold ended early");
    extest_drive_a: assert property ( // [R04]
        port_en && ir_ff == `IR_EXTEST |=> pin_oe_ff == $past(latch_bus.oe))
        else $error("external test not driving latches");
    preload_iso_a: assert property ( // [R13]
        ir_ff == `IR_SAMPLE && !core_reset_ff |=> pin_out_ff == $past(core_pins.out))
        else $error("preload disturbed pins");
    reset_tristate_a: assert property ( // [R19]
        core_reset_ff && ir_ff != `IR_EXTEST |=> pin_oe_ff == '0)
        else $error("pins driven in reset");
    port_off_a: assert property ( // [R22]
        !port_en |=> state_ff == TLR && !tdo_oe_ff)
        else $error("port active while disabled");
    ir_lsb_out_a: assert property ( // [R02]
        port_en && tck_fall && state_ff == SH_IR |=> tdo_ff == $past(ir_sr_ff[0]))
        else $error("instruction not shifted LSB first");

    extest_cov_c: cover property (ir_ff == `IR_EXTEST && chain_ctl.update);
    devrst_cov_c: cover property (sel_rst && rst_bit_ff);
    bypass_cov_c: cover property (ir_ff == `IR_BYPASS && state_ff == SH_DR);
endmodule

// >>> sim/scan_host.sv
// Purpose: board test controller model driving the four-wire test port
// Assumes: bench clock of 20 ns; test clock period of 160 ns
// Notes: test clock stands low between scans; tdi flips when released
`timescale 1ns/10ps
module scan_host (
    input wire logic clock, // Bench clock
    input wire logic tdo, // Serial data from the device
    output logic tck, // Test clock
    output logic tms, // Mode select
    output logic tdi // Serial data to the device
);
    // ==========================================================
    // Idle levels
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // One test clock period; inputs change mid low phase, well clear of the
    // sampled rise, and tdo is read just before the fall
    task step(input logic m, input logic d, output logic o);
        repeat (2) @(negedge clock);
        tms = m;
        tdi = d;
        repeat (2) @(negedge clock);
        tck = 1'b1;
        repeat (4) @(negedge clock);
        o = tdo;
        tck = 1'b0;
    endtask

    // Scan from and back to Run-Test/Idle
    task scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic o;
        dout = '0;
        step(1'b1, tdi, o);
        if (ir) step(1'b1, tdi, o);
        step(1'b0, tdi, o);
        step(1'b0, tdi, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, ~tdi, o);
        step(1'b0, ~tdi, o);
    endtask
endmodule

// >>> sim/tb_bscan_top.sv
// Purpose: self-checking bench of the boundary-scan test logic
// Assumes: scan_host plays the board test controller
// Notes: long start-up count shortened, short count left at full length
`timescale 1ns/10ps
module tb_bscan_top;
    import bscan_pkg::*;
    typedef struct {logic [3:0] op; int n; logic [31:0] din; logic [31:0] exp;} row_s;
    localparam logic [31:0] ID_WORD = {4'h3, 16'h5A5A, 11'h155, 1'b1};
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic dis = 1'b0;
    logic seen = 1'b0;
    logic oe_seen = 1'b0;
    logic fuse = 1'b1;
    logic ext_rst_n = 1'b1;
    logic opt_long = 1'b0;
    logic tck, tms, tdi, tdo, tdo_oe, core_reset, pullup_dis, o;
    logic [7:0] pin_in = 8'hA5;
    logic [7:0] pin_out, pin_oe;
    pin_bus_s cp = '{out: 8'h33, oe: 8'h0F};
    logic [31:0] d;
    row_s rows[5];
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;

    // ==========================================================
    // Clock, partner and device
    always #10 clock = ~clock;
    scan_host host (.clock(clock), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
    bscan_top #(.ID_VERSION(4'h3), .ID_PART(16'h5A5A), .ID_MAKER(11'h155),
        .STARTUP_LONG_CYC(20)) uut (.clock(clock), .srst(srst), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .test_port_enable_fuse(fuse),
        .test_port_disable_bit(dis), .ext_reset_n(ext_rst_n), .clk_opt_long(opt_long),
        .core_pins(cp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_dis(pullup_dis), .core_reset(core_reset));

    // Hang guard and watch of tdo enable while disabled
    always @(posedge clock) begin
        cyc++;
        if (tdo_oe !== 1'b0 && (dis || !fuse)) seen <= 1'b1;
        if (tdo_oe === 1'b1) oe_seen <= 1'b1;
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end

    // ==========================================================
    // Helpers
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask

    task ld(input logic [3:0] op);
        host.scan(1'b1, 4, {28'h0, op}, d);
        chk("ir_capture", 32'h1, d);
    endtask

    // Chain image: control at even bits, data at odd bits
    function automatic logic [31:0] chain(input logic [7:0] dat, input logic [7:0] ctl);
        chain = '0;
        for (int i = 0; i < 8; i++) begin
            chain[2*i] = ctl[i];
            chain[2*i+1] = dat[i];
        end
    endfunction

    task test_done;
        if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        rows = '{'{4'h1, 32, 32'h0, ID_WORD}, '{4'hF, 2, 32'h1, 32'h2},
            '{4'h5, 2, 32'h1, 32'h2}, '{4'h9, 2, 32'h1, 32'h2},
            '{4'h2, 16, chain(8'h3C, 8'hF0), chain(8'hA5, 8'h0F)}};
        repeat (10) @(negedge clock);
        srst = 1'b0;
        repeat (6) @(negedge clock);
        host.step(1'b0, 1'b0, o);
        host.scan(1'b0, 32, 32'h0, d);
        chk("id_default", ID_WORD, d);
        foreach (rows[k]) begin
            ld(rows[k].op);
            host.scan(1'b0, rows[k].n, rows[k].din, d);
            chk("dr_scan", rows[k].exp, d);
        end
        // Preload above keeps the board safe when external test starts
        chk("pins_kept", {16'h0, 8'h33, 8'h0F}, {16'h0, pin_out, pin_oe});
        ld(4'h0);
        chk("extest_drive", {16'h0, 8'h3C, 8'hF0}, {16'h0, pin_out, pin_oe});
        chk("pullup_dis", 32'h1, {31'h0, pullup_dis});
        host.scan(1'b0, 16, chain(8'h96, 8'hFF), d);
        chk("extest_cap", chain(8'hA5, 8'hF0), d);
        chk("extest_upd", {16'h0, 8'h96, 8'hFF}, {16'h0, pin_out, pin_oe});
        // Reset bit set, then cleared with the start-up count running
        ld(4'hC);
        host.scan(1'b0, 1, 32'h1, d);
        chk("rst_held", 32'h1, {31'h0, core_reset});
        chk("rst_tristate", 32'h0, {24'h0, pin_oe});
        host.scan(1'b0, 1, 32'h0, d);
        chk("rst_bit_out", 32'h1, d);
        chk("rst_startup", 32'h1, {31'h0, core_reset});
        repeat (3300) @(negedge clock);
        chk("rst_release", 32'h0, {31'h0, core_reset});
        // External reset pin, then the long start-up count of 20 cycles
        opt_long = 1'b1;
        ext_rst_n = 1'b0;
        repeat (8) @(negedge clock);
        chk("ext_rst_held", 32'h1, {31'h0, core_reset});
        chk("ext_rst_oe", 32'h0, {24'h0, pin_oe});
        ext_rst_n = 1'b1;
        repeat (10) @(negedge clock);
        chk("long_startup", 32'h1, {31'h0, core_reset});
        repeat (20) @(negedge clock);
        chk("long_release", 32'h0, {31'h0, core_reset});
        // Disabled port, by bit then by fuse, ignores scans
        dis = 1'b1;
        host.scan(1'b1, 4, 32'hF, d);
        dis = 1'b0;
        fuse = 1'b0;
        host.step(1'b0, 1'b0, o);
        host.scan(1'b1, 4, 32'hC, d);
        fuse = 1'b1;
        host.step(1'b0, 1'b0, o);
        host.scan(1'b0, 32, 32'h0, d);
        chk("disabled_id", ID_WORD, d);
        chk("disabled_oe", 32'h0, {31'h0, seen});
        // Five mode-select highs return to Test-Logic-Reset
        ld(4'hF);
        repeat (5) host.step(1'b1, 1'b0, o);
        host.step(1'b0, 1'b0, o);
        host.scan(1'b0, 32, 32'h0, d);
        chk("tms_reset_id", ID_WORD, d);
        chk("tdo_oe_used", 32'h1, {31'h0, oe_seen});
        test_done();
    end
endmodule
